// *** hcs_cfg.svh ***
// constants for the home and coordinate setup block: object indices, resets, field codes
// assumes it is included by its bare name
`ifndef HCS_CFG_SVH
`define HCS_CFG_SVH
`define HCS_IDX_ABS_PERMIT 16'h4148
`define HCS_IDX_ROT_DIR 16'h41c2
`define HCS_IDX_WRAP_EN 16'h41c7
`define HCS_IDX_WRAP_RANGE 16'h41c9
`define HCS_IDX_WRAP_RATIO 16'h41cb
`define HCS_IDX_WRAP_OFFS 16'h41cc
`define HCS_IDX_WRAP_ZCNT 16'h41cd
`define HCS_IDX_MECH_SEL 16'h47f0
`define HCS_IDX_GEAR 16'h47f1
`define HCS_IDX_CGEN_SEL 16'h47f2
`define HCS_IDX_LIMIT_SEL 16'h47f3
`define HCS_IDX_PROT_SEL 16'h47f4
`define HCS_IDX_JOG_SEL 16'h47f5
`define HCS_IDX_HOME_OFFS 16'h607c
`define HCS_RST_ABS_PERMIT 8'h00
`define HCS_RST_ROT_DIR 8'h01
`define HCS_RST_WRAP_EN 8'h01
`define HCS_RST_WRAP_RANGE 32'h0000000a
`define HCS_RST_WRAP_RATIO 16'h1388
`define HCS_RST_WRAP_OFFS 32'h00000000
`define HCS_RST_WRAP_ZCNT 16'h0001
`define HCS_RST_MECH_SEL 8'h01
`define HCS_RST_GEAR 16'h0000
`define HCS_RST_CGEN_SEL 8'h00
`define HCS_RST_LIMIT_SEL 8'h00
`define HCS_RST_PROT_SEL 8'h00
`define HCS_RST_JOG_SEL 8'h00
`define HCS_RST_HOME_OFFS 32'h00000000
`define HCS_GEAR_MAX 16'h7fff
`define HCS_ROT_BIT_CW 0
`define HCS_ROT_BIT_DRV 1
`endif

// *** hcs_encoder_model.sv ***
// behavioural absolute encoder feeding the present position
// assumes the block's clock and reset
`timescale 1ns/1ps
`default_nettype none
module hcs_encoder_model (
   input wire logic i_clock,
   input wire logic i_resetn,
   output logic [31:0] o_position
);
   // shaft creeps every cycle, so a capture on the wrong edge is seen
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         o_position <= 32'h00001000;
      end else begin
         o_position <= o_position + 32'h00000003;
      end
   end
endmodule : hcs_encoder_model
`default_nettype wire

// *** hcs_pkg.sv ***
// types for the home and coordinate setup block
// assumes hcs_cfg.svh is compiled alongside
package hcs_pkg;
   typedef enum logic [2:0] {
      HCS_UNSET = 3'b001,
      HCS_HOMING = 3'b010,
      HCS_SET = 3'b100
   } hcs_coord_t;
   typedef struct packed {
      logic [7:0] abs_permit;
      logic [7:0] rot_dir;
      logic [7:0] wrap_en;
      logic [31:0] wrap_range;
      logic [15:0] wrap_ratio;
      logic [31:0] wrap_offs;
      logic [15:0] wrap_zcnt;
      logic [7:0] mech_sel;
      logic [15:0] gear;
      logic [7:0] cgen_sel;
      logic [7:0] limit_sel;
      logic [7:0] prot_sel;
      logic [7:0] jog_sel;
      logic [31:0] home_offs;
   } hcs_regs_t;
endpackage : hcs_pkg

// *** hcs_src_if.sv ***
// carries the sensor-versus-manual source choices from the latch to the top
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface hcs_src_if;
   logic [4:0] live_sel;
   logic [4:0] power_sel;
   modport latch (input live_sel, output power_sel);
   modport user (output live_sel, input power_sel);
endinterface : hcs_src_if
`default_nettype wire

// *** hcs_src_latch.sv ***
// latches the five parameter source selectors when control power comes on
// assumes i_power_on is a one-cycle pulse synchronous to i_clock
`timescale 1ns/1ps
`default_nettype none
module hcs_src_latch
   import hcs_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_power_on,
   hcs_src_if.latch src
);
   typedef struct packed {
      logic [4:0] sel;
   } hcs_latch_t;
   hcs_latch_t state;
   hcs_latch_t next_state;
   // reset value matches the selector resets: only mechanism defaults to manual
   always_comb begin
      next_state = state;
      if (i_power_on) begin
         next_state.sel = src.live_sel;
      end
   end
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         state.sel <= 5'h01;
      end else begin
         state <= next_state;
      end
   end
   assign src.power_sel = state.sel;
endmodule : hcs_src_latch
`default_nettype wire

// *** hcs_tb_top.sv ***
// self-checking bench for the home and coordinate setup block
// assumes the design files, hcs_checker and hcs_encoder_model are compiled first
`include "hcs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module home_and_coordinate_setup_tb_top;
   localparam logic [5:0] PWR = 6'h01, PRE = 6'h02, CLR = 6'h04, HST = 6'h08, HDN = 6'h10;
   localparam logic [5:0] RES = 6'h20;
   localparam logic [15:0] RI [10] = '{`HCS_IDX_ABS_PERMIT, `HCS_IDX_ROT_DIR, `HCS_IDX_MECH_SEL,
      `HCS_IDX_GEAR, `HCS_IDX_CGEN_SEL, `HCS_IDX_LIMIT_SEL, `HCS_IDX_PROT_SEL, `HCS_IDX_JOG_SEL,
      `HCS_IDX_HOME_OFFS, `HCS_IDX_WRAP_EN};
   localparam logic [31:0] RV [10] = '{0, 1, 1, 0, 0, 0, 0, 0, 0, 1};
   localparam logic [15:0] SI [5] = '{`HCS_IDX_MECH_SEL, `HCS_IDX_CGEN_SEL, `HCS_IDX_LIMIT_SEL,
      `HCS_IDX_PROT_SEL, `HCS_IDX_JOG_SEL};
   logic i_clock, i_resetn, wr, rd, req, o_obj_ack, o_obj_err, o_coords_valid_out;
   logic o_abs_move_grant, o_pos_load, o_dir_cw, o_dir_drv_param, o_gear_enable, o_wrap_enable;
   logic o_wrap_manual, o_mech_manual, o_limit_from_sensor, o_protect_from_sensor;
   logic o_jog_homing_manual;
   logic [5:0] ev;
   logic [14:0] o_gear_ratio;
   logic [15:0] idx;
   logic [31:0] wdata, snap, enc_pos, o_obj_rdata, o_command_pos, o_feedback_pos, o_home_pos;
   logic [31:0] o_wrap_range, o_wrap_offset;
   logic [15:0] o_wrap_ratio, o_wrap_zero_count;
   int fail_count, total_checks, cyc;
   hcs_encoder_model u_enc (.i_clock, .i_resetn, .o_position(enc_pos));
   hcs_top u_dut (.i_clock, .i_resetn, .i_power_on(ev[0]), .i_obj_wr(wr), .i_obj_rd(rd),
      .i_obj_index(idx), .i_obj_wdata(wdata), .i_preset(ev[1]), .i_preset_clear(ev[2]),
      .i_homing_start(ev[3]), .i_homing_done(ev[4]), .i_resolution_change(ev[5]),
      .i_abs_move_req(req), .i_feedback_pos(enc_pos), .o_obj_rdata, .o_obj_ack, .o_obj_err,
      .o_coords_valid_out, .o_abs_move_grant, .o_pos_load, .o_command_pos, .o_feedback_pos,
      .o_home_pos, .o_dir_cw, .o_dir_drv_param, .o_gear_enable, .o_gear_ratio, .o_wrap_enable,
      .o_wrap_manual, .o_wrap_range, .o_wrap_ratio, .o_wrap_offset, .o_wrap_zero_count,
      .o_mech_manual, .o_limit_from_sensor, .o_protect_from_sensor, .o_jog_homing_manual);
   // ****
   // tasks
   // ****
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one object access; write data and read data share the flow, err is the expected refusal
   task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d,
      input logic [31:0] x, input logic e);
      @(posedge i_clock);
      wr <= w;
      rd <= !w;
      idx <= i;
      wdata <= d;
      @(posedge i_clock);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      check(o_obj_ack, 1'b1);
      check(o_obj_err, e);
      if (!w) check(o_obj_rdata, x);
   endtask : acc
   task automatic pulse(input logic [5:0] e);
      @(posedge i_clock);
      ev <= e;
      #1;
      snap = enc_pos;
      @(posedge i_clock);
      ev <= 6'h00;
      #1;
   endtask : pulse
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report
   // ****
   // clock, timeout, tests
   // ****
   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         final_report;
      end
   end
   initial begin
      {i_resetn, wr, rd, req, ev, idx, wdata} = '0;
      repeat (4) @(posedge i_clock);
      i_resetn <= 1'b1;
      for (int k = 0; k < 10; k++) acc(1'b0, RI[k], 0, RV[k], 1'b0);
      check(o_coords_valid_out, 1'b0);
      check(o_wrap_ratio, 32'h1388);
      check(o_wrap_offset, 32'h0);
      check(o_wrap_zero_count, 32'h1);
      $display("test reset values done");
      acc(1'b1, `HCS_IDX_ABS_PERMIT, 32'h2, 0, 1'b1);
      acc(1'b0, `HCS_IDX_ABS_PERMIT, 0, 32'h0, 1'b0);
      acc(1'b1, `HCS_IDX_GEAR, 32'h7fff, 0, 1'b0);
      acc(1'b1, `HCS_IDX_GEAR, 32'h8000, 0, 1'b1);
      check(o_gear_ratio, 15'h7fff);
      acc(1'b1, `HCS_IDX_GEAR, 32'h0, 0, 1'b0);
      check(o_gear_enable, 1'b0);
      for (int k = 0; k < 4; k++) begin
         acc(1'b1, `HCS_IDX_ROT_DIR, k, 0, 1'b0);
         check({o_dir_drv_param, o_dir_cw}, k);
      end
      acc(1'b1, `HCS_IDX_ROT_DIR, 32'h4, 0, 1'b1);
      acc(1'b1, `HCS_IDX_WRAP_ZCNT, 32'h1, 0, 1'b0);
      check(o_wrap_zero_count, 32'h1);
      acc(1'b1, `HCS_IDX_WRAP_RATIO, 32'h1f4, 0, 1'b0);
      check(o_wrap_ratio, 32'h1f4);
      acc(1'b0, `HCS_IDX_WRAP_ZCNT, 0, 32'h1, 1'b0);
      acc(1'b1, `HCS_IDX_WRAP_RANGE, 32'h3e8, 0, 1'b0);
      check(o_wrap_range, 32'h3e8);
      acc(1'b0, 16'h1234, 0, 32'h0, 1'b1);
      $display("test objects done");
      @(posedge i_clock);
      req <= 1'b1;
      acc(1'b1, `HCS_IDX_HOME_OFFS, 32'h80000000, 0, 1'b0);
      check(o_abs_move_grant, 1'b0);
      pulse(PRE);
      check(o_pos_load, 1'b1);
      check(o_command_pos, 32'h80000000);
      check(o_feedback_pos, 32'h80000000);
      check(o_coords_valid_out, 1'b1);
      @(posedge i_clock);
      #1;
      check(o_pos_load, 1'b0);
      check(o_abs_move_grant, 1'b1);
      pulse(RES);
      check(o_coords_valid_out, 1'b0);
      @(posedge i_clock);
      #1;
      check(o_abs_move_grant, 1'b0);
      acc(1'b1, `HCS_IDX_ABS_PERMIT, 32'h1, 0, 1'b0);
      @(posedge i_clock);
      #1;
      check(o_abs_move_grant, 1'b1);
      $display("test preset done");
      pulse(HST);
      check(o_coords_valid_out, 1'b0);
      pulse(PRE);
      check(o_pos_load, 1'b0);
      pulse(HDN);
      check(o_coords_valid_out, 1'b1);
      check(o_home_pos, snap);
      pulse(RES);
      check(o_coords_valid_out, 1'b1);
      pulse(CLR);
      check(o_coords_valid_out, 1'b0);
      $display("test homing done");
      for (int k = 0; k < 5; k++) acc(1'b1, SI[k], k != 0, 0, 1'b0);
      acc(1'b1, `HCS_IDX_WRAP_EN, 32'h0, 0, 1'b0);
      check(o_wrap_enable, 1'b0);
      check({o_mech_manual, o_wrap_manual, o_limit_from_sensor, o_protect_from_sensor,
         o_jog_homing_manual}, 5'h16);
      pulse(PWR);
      check({o_mech_manual, o_wrap_manual, o_limit_from_sensor, o_protect_from_sensor,
         o_jog_homing_manual}, 5'h09);
      $display("test selectors done");
      final_report;
   end
endmodule : home_and_coordinate_setup_tb_top
bind hcs_top hcs_checker u_chk (.i_clock, .i_resetn, .i_power_on, .i_obj_wr, .i_obj_rd,
   .i_preset, .i_preset_clear, .i_homing_start, .i_homing_done, .i_resolution_change,
   .i_abs_move_req, .o_obj_ack, .o_coords_valid_out, .o_abs_move_grant, .o_pos_load,
   .o_command_pos, .o_feedback_pos, .o_gear_enable, .o_gear_ratio, .o_mech_manual,
   .o_wrap_manual, .o_jog_homing_manual);
`default_nettype wire

// *** hcs_top.sv ***
// home and coordinate setup: object store, home preset, coordinates-valid tracking
// assumes a fieldbus front end that presents one object write or read per cycle
//
// Summary of operation
// - preset loads command and feedback with offset
// - home offset signed 32-bit, reset zero
// - absolute move unset only if permit one
// - homing completion also sets the home
// - motion centred on home once set
// - unset at shipment, resolution change after a nonzero-offset preset, clear, homing
// - mechanism selector reset one, needs power cycle
// - gear zero disables, else ratio hundredths
// - coordinate selector one takes manual wrap values
// - limit selector zero applies sensor limits
// - protection selector zero applies sensor protection
// - jog selector one takes manual homing values
// - rotation direction codes, reset clockwise
// - wrap range tenths rev, ratio hundredths percent
// - wrap zero pulse count per range settable
// - coordinates valid once home is set
// - wrap enable zero off one on, reset one
`include "hcs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module hcs_top
   import hcs_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_power_on,
   input wire logic i_obj_wr,
   input wire logic i_obj_rd,
   input wire logic [15:0] i_obj_index,
   input wire logic [31:0] i_obj_wdata,
   input wire logic i_preset,
   input wire logic i_preset_clear,
   input wire logic i_homing_start,
   input wire logic i_homing_done,
   input wire logic i_resolution_change,
   input wire logic i_abs_move_req,
   input wire logic [31:0] i_feedback_pos,
   output logic [31:0] o_obj_rdata,
   output logic o_obj_ack,
   output logic o_obj_err,
   output logic o_coords_valid_out,
   output logic o_abs_move_grant,
   output logic o_pos_load,
   output logic [31:0] o_command_pos,
   output logic [31:0] o_feedback_pos,
   output logic [31:0] o_home_pos,
   output logic o_dir_cw,
   output logic o_dir_drv_param,
   output logic o_gear_enable,
   output logic [14:0] o_gear_ratio,
   output logic o_wrap_enable,
   output logic o_wrap_manual,
   output logic [31:0] o_wrap_range,
   output logic [15:0] o_wrap_ratio,
   output logic [31:0] o_wrap_offset,
   output logic [15:0] o_wrap_zero_count,
   output logic o_mech_manual,
   output logic o_limit_from_sensor,
   output logic o_protect_from_sensor,
   output logic o_jog_homing_manual
);
   // ************************************************
   // state
   // ************************************************
   typedef struct packed {
      hcs_regs_t regs;
      hcs_coord_t coord;
      logic offs_nonzero;
      logic [31:0] rdata;
      logic ack;
      logic err;
      logic grant;
      logic load;
      logic [31:0] cmd_pos;
      logic [31:0] fb_pos;
      logic [31:0] home_pos;
      logic valid;
      logic gear_en;
   } hcs_state_t;
   hcs_state_t state;
   hcs_state_t next_state;
   hcs_src_if src();
   hcs_src_latch u_src_latch (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_power_on(i_power_on),
      .src(src.latch)
   );
   // live selector bits: mech, coord-gen, limit, protect, jog
   assign src.live_sel = {state.regs.jog_sel[0], state.regs.prot_sel[0],
      state.regs.limit_sel[0], state.regs.cgen_sel[0], state.regs.mech_sel[0]};
   // ************************************************
   // next state
   // ************************************************
   always_comb begin
      next_state = state;
      next_state.ack = 1'b0;
      next_state.err = 1'b0;
      next_state.load = 1'b0;
      if (i_obj_wr) begin
         next_state.ack = 1'b1;
         unique case (i_obj_index)
            `HCS_IDX_ABS_PERMIT: begin
               next_state.err = (i_obj_wdata > 32'h1);
               if (i_obj_wdata <= 32'h1) next_state.regs.abs_permit = i_obj_wdata[7:0];
            end
            `HCS_IDX_ROT_DIR: begin
               next_state.err = (i_obj_wdata > 32'h3);
               if (i_obj_wdata <= 32'h3) next_state.regs.rot_dir = i_obj_wdata[7:0];
            end
            `HCS_IDX_WRAP_EN: begin
               next_state.err = (i_obj_wdata > 32'h1);
               if (i_obj_wdata <= 32'h1) next_state.regs.wrap_en = i_obj_wdata[7:0];
            end
            `HCS_IDX_WRAP_RANGE: next_state.regs.wrap_range = i_obj_wdata;
            `HCS_IDX_WRAP_RATIO: next_state.regs.wrap_ratio = i_obj_wdata[15:0];
            `HCS_IDX_WRAP_OFFS: next_state.regs.wrap_offs = i_obj_wdata;
            `HCS_IDX_WRAP_ZCNT: next_state.regs.wrap_zcnt = i_obj_wdata[15:0];
            `HCS_IDX_MECH_SEL: begin
               next_state.err = (i_obj_wdata > 32'h1);
               if (i_obj_wdata <= 32'h1) next_state.regs.mech_sel = i_obj_wdata[7:0];
            end
            `HCS_IDX_GEAR: begin
               next_state.err = (i_obj_wdata > {16'h0, `HCS_GEAR_MAX});
               if (i_obj_wdata <= {16'h0, `HCS_GEAR_MAX}) begin
                  next_state.regs.gear = i_obj_wdata[15:0];
               end
            end
            `HCS_IDX_CGEN_SEL: begin
               next_state.err = (i_obj_wdata > 32'h1);
               if (i_obj_wdata <= 32'h1) next_state.regs.cgen_sel = i_obj_wdata[7:0];
            end
            `HCS_IDX_LIMIT_SEL: begin
               next_state.err = (i_obj_wdata > 32'h1);
               if (i_obj_wdata <= 32'h1) next_state.regs.limit_sel = i_obj_wdata[7:0];
            end
            `HCS_IDX_PROT_SEL: begin
               next_state.err = (i_obj_wdata > 32'h1);
               if (i_obj_wdata <= 32'h1) next_state.regs.prot_sel = i_obj_wdata[7:0];
            end
            `HCS_IDX_JOG_SEL: begin
               next_state.err = (i_obj_wdata > 32'h1);
               if (i_obj_wdata <= 32'h1) next_state.regs.jog_sel = i_obj_wdata[7:0];
            end
            `HCS_IDX_HOME_OFFS: next_state.regs.home_offs = i_obj_wdata;
            default: next_state.err = 1'b1;
         endcase
      end else if (i_obj_rd) begin
         next_state.ack = 1'b1;
         next_state.rdata = 32'h0;
         unique case (i_obj_index)
            `HCS_IDX_ABS_PERMIT: next_state.rdata = {24'h0, state.regs.abs_permit};
            `HCS_IDX_ROT_DIR: next_state.rdata = {24'h0, state.regs.rot_dir};
            `HCS_IDX_WRAP_EN: next_state.rdata = {24'h0, state.regs.wrap_en};
            `HCS_IDX_WRAP_RANGE: next_state.rdata = state.regs.wrap_range;
            `HCS_IDX_WRAP_RATIO: next_state.rdata = {16'h0, state.regs.wrap_ratio};
            `HCS_IDX_WRAP_OFFS: next_state.rdata = state.regs.wrap_offs;
            `HCS_IDX_WRAP_ZCNT: next_state.rdata = {16'h0, state.regs.wrap_zcnt};
            `HCS_IDX_MECH_SEL: next_state.rdata = {24'h0, state.regs.mech_sel};
            `HCS_IDX_GEAR: next_state.rdata = {16'h0, state.regs.gear};
            `HCS_IDX_CGEN_SEL: next_state.rdata = {24'h0, state.regs.cgen_sel};
            `HCS_IDX_LIMIT_SEL: next_state.rdata = {24'h0, state.regs.limit_sel};
            `HCS_IDX_PROT_SEL: next_state.rdata = {24'h0, state.regs.prot_sel};
            `HCS_IDX_JOG_SEL: next_state.rdata = {24'h0, state.regs.jog_sel};
            `HCS_IDX_HOME_OFFS: next_state.rdata = state.regs.home_offs;
            default: next_state.err = 1'b1;
         endcase
      end
      // coordinate state; homing start has priority since coords are unset throughout
      unique case (state.coord)
         HCS_UNSET, HCS_SET: begin
            if (i_homing_start) begin
               next_state.coord = HCS_HOMING;
            end else if (i_preset) begin
               next_state.coord = HCS_SET;
               next_state.load = 1'b1;
               next_state.cmd_pos = state.regs.home_offs;
               next_state.fb_pos = state.regs.home_offs;
               next_state.home_pos = i_feedback_pos;
               next_state.offs_nonzero = (state.regs.home_offs != 32'h0);
            end else if (i_preset_clear) begin
               next_state.coord = HCS_UNSET;
            end else if (i_resolution_change && state.offs_nonzero) begin
               next_state.coord = HCS_UNSET;
            end
         end
         HCS_HOMING: begin
            if (i_homing_done) begin
               next_state.coord = HCS_SET;
               next_state.home_pos = i_feedback_pos;
               next_state.offs_nonzero = 1'b0;
            end
         end
         default: next_state.coord = HCS_UNSET;
      endcase
      // flags registered from next values so the outputs come straight from flops
      next_state.valid = (next_state.coord == HCS_SET);
      next_state.gear_en = (next_state.regs.gear != 16'h0);
      // gating uses the registered state, so grant lags the request by one cycle
      next_state.grant = i_abs_move_req &&
         ((state.coord == HCS_SET) || (state.regs.abs_permit == 8'h01));
   end
   // ************************************************
   // registers
   // ************************************************
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         state.regs.abs_permit <= `HCS_RST_ABS_PERMIT;
         state.regs.rot_dir <= `HCS_RST_ROT_DIR;
         state.regs.wrap_en <= `HCS_RST_WRAP_EN;
         state.regs.wrap_range <= `HCS_RST_WRAP_RANGE;
         state.regs.wrap_ratio <= `HCS_RST_WRAP_RATIO;
         state.regs.wrap_offs <= `HCS_RST_WRAP_OFFS;
         state.regs.wrap_zcnt <= `HCS_RST_WRAP_ZCNT;
         state.regs.mech_sel <= `HCS_RST_MECH_SEL;
         state.regs.gear <= `HCS_RST_GEAR;
         state.regs.cgen_sel <= `HCS_RST_CGEN_SEL;
         state.regs.limit_sel <= `HCS_RST_LIMIT_SEL;
         state.regs.prot_sel <= `HCS_RST_PROT_SEL;
         state.regs.jog_sel <= `HCS_RST_JOG_SEL;
         state.regs.home_offs <= `HCS_RST_HOME_OFFS;
         state.coord <= HCS_UNSET;
         state.offs_nonzero <= 1'b0;
         state.rdata <= 32'h0;
         state.ack <= 1'b0;
         state.err <= 1'b0;
         state.grant <= 1'b0;
         state.load <= 1'b0;
         state.cmd_pos <= 32'h0;
         state.fb_pos <= 32'h0;
         state.home_pos <= 32'h0;
         state.valid <= 1'b0;
         state.gear_en <= 1'b0;
      end else begin
         state <= next_state;
      end
   end
   // ************************************************
   // outputs
   // ************************************************
   // selector outputs use the power-up copy, so writes wait for a power cycle
   assign o_obj_rdata = state.rdata;
   assign o_obj_ack = state.ack;
   assign o_obj_err = state.err;
   assign o_coords_valid_out = state.valid;
   assign o_abs_move_grant = state.grant;
   assign o_pos_load = state.load;
   assign o_command_pos = state.cmd_pos;
   assign o_feedback_pos = state.fb_pos;
   assign o_home_pos = state.home_pos;
   assign o_dir_cw = state.regs.rot_dir[`HCS_ROT_BIT_CW];
   assign o_dir_drv_param = state.regs.rot_dir[`HCS_ROT_BIT_DRV];
   assign o_gear_enable = state.gear_en;
   assign o_gear_ratio = state.regs.gear[14:0];
   assign o_wrap_enable = state.regs.wrap_en[0];
   assign o_wrap_manual = src.power_sel[1];
   assign o_wrap_range = state.regs.wrap_range;
   assign o_wrap_ratio = state.regs.wrap_ratio;
   assign o_wrap_offset = state.regs.wrap_offs;
   assign o_wrap_zero_count = state.regs.wrap_zcnt;
   assign o_mech_manual = src.power_sel[0];
   assign o_limit_from_sensor = !src.power_sel[2];
   assign o_protect_from_sensor = !src.power_sel[3];
   assign o_jog_homing_manual = src.power_sel[4];
endmodule : hcs_top
`default_nettype wire

// *** hcs_top_assertions.sv ***
// concurrent checks on the home and coordinate setup top-level ports
// assumes a bind to hcs_top; one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module hcs_checker (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_power_on,
   input wire logic i_obj_wr,
   input wire logic i_obj_rd,
   input wire logic i_preset,
   input wire logic i_preset_clear,
   input wire logic i_homing_start,
   input wire logic i_homing_done,
   input wire logic i_resolution_change,
   input wire logic i_abs_move_req,
   input wire logic o_obj_ack,
   input wire logic o_coords_valid_out,
   input wire logic o_abs_move_grant,
   input wire logic o_pos_load,
   input wire logic [31:0] o_command_pos,
   input wire logic [31:0] o_feedback_pos,
   input wire logic o_gear_enable,
   input wire logic [14:0] o_gear_ratio,
   input wire logic o_mech_manual,
   input wire logic o_wrap_manual,
   input wire logic o_jog_homing_manual
);
   // ****
   // helpers
   // ****
   logic homing;
   logic unset_ev;
   logic preset_go;
   assign unset_ev = i_homing_start | i_preset_clear | i_resolution_change;
   // presets are refused while homing, so the mirror flag keeps them out of the checks
   assign preset_go = i_preset & ~i_homing_start & ~homing;
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         homing <= 1'b0;
      end else if (i_homing_start) begin
         homing <= 1'b1;
      end else if (i_homing_done) begin
         homing <= 1'b0;
      end
   end
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_resetn);
   // ****
   // properties
   // ****
   ack_follows_req_a: assert property ((i_obj_wr || i_obj_rd) |=> o_obj_ack)
      else $error("object access without acknowledge");
   preset_loads_pos_a: assert property (preset_go |=> o_pos_load && o_command_pos == o_feedback_pos)
      else $error("preset did not load positions");
   preset_sets_valid_a: assert property (preset_go |=> o_coords_valid_out)
      else $error("coordinates not valid after preset");
   homing_start_unset_a: assert property (i_homing_start |=> !o_coords_valid_out)
      else $error("coordinates valid after homing start");
   homing_keeps_unset_a: assert property (homing && !i_homing_done |=> !o_coords_valid_out)
      else $error("coordinates valid during homing");
   homing_done_set_a: assert property (homing && i_homing_done && !i_homing_start |=> o_coords_valid_out)
      else $error("homing completion did not set coordinates");
   clear_unsets_a: assert property (i_preset_clear && !i_preset && !i_homing_start && !homing
      |=> !o_coords_valid_out)
      else $error("preset clear left coordinates valid");
   grant_when_set_a: assert property (i_abs_move_req && o_coords_valid_out && !unset_ev
      |=> o_abs_move_grant)
      else $error("absolute move refused with coordinates set");
   no_req_grant_a: assert property (!i_abs_move_req |=> !o_abs_move_grant)
      else $error("grant without request");
   source_latched_a: assert property (!i_power_on
      |=> $stable({o_mech_manual, o_wrap_manual, o_jog_homing_manual}))
      else $error("source selection changed without power on");
   gear_enable_a: assert property (o_gear_enable == (o_gear_ratio != 15'h0))
      else $error("gear enable disagrees with ratio");
   cover property (preset_go ##1 o_coords_valid_out);
   cover property (homing && i_homing_done);
   cover property (o_abs_move_grant);
endmodule : hcs_checker
`default_nettype wire
